// ---- rtl/bit_manip_unit.sv ----
// single-bit manipulation datapath with register and memory operands
//
// Behaviour
// - set writes 1 into selected bit
// - clear writes 0 into selected bit
// - invert complements selected bit, writes back
// - test: zero flag gets inverted bit
// - set/clear/invert/test: immediate or register bit number
// - carry and: C and bit
// - inverted carry and: C and not bit
// - carry or: C or bit
// - inverted carry or: C or not bit
// - carry xor: C xor bit
// - inverted carry xor: C xor not bit
// - bit load copies bit into carry
// - inverted load copies not bit into carry
// - store writes carry into selected bit
// - inverted store writes not carry into bit
// - carry ops use immediate bit number only
`default_nettype none
module bit_manip_unit
  import bit_manip_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          start,
  input  wire bit_manip_pkg::op_t            op,
  input  wire logic                          use_mem,
  input  wire logic                          bitno_from_reg,
  input  wire logic [bit_manip_pkg::BITNO_W-1:0] imm_bitno,
  input  wire logic [bit_manip_pkg::BYTE_W-1:0]  bitno_reg,
  input  wire logic [bit_manip_pkg::BYTE_W-1:0]  reg_operand,
  input  wire logic                          carry_in,
  input  wire logic [bit_manip_pkg::BYTE_W-1:0]  mem_rdata,
  input  wire logic                          mem_ack,
  output logic                               busy_ff,
  output logic                               done_ff,
  output logic [bit_manip_pkg::BYTE_W-1:0]   reg_result_ff,
  output logic                               reg_we_ff,
  output logic                               carry_out_ff,
  output logic                               carry_we_ff,
  output logic                               zero_out_ff,
  output logic                               zero_we_ff,
  output logic                               mem_rd_ff,
  output logic                               mem_wr_ff,
  output logic [bit_manip_pkg::BYTE_W-1:0]   mem_wdata_ff
);
  import bit_manip_pkg::*;

  // ----------------------------------------
  // operand capture and bit selection
  // ----------------------------------------
  state_t                state_ff;
  op_t                   op_ff;
  logic [BITNO_W-1:0]    bitno_ff;
  logic                  carry_ff;
  logic [BYTE_W-1:0]     operand;
  logic [BYTE_W-1:0]     mask;
  logic                  sel_bit;
  logic [BYTE_W-1:0]     new_byte;
  logic                  writes_byte;
  logic                  new_carry;
  logic                  carry_op;
  logic [BITNO_W-1:0]    nxt_bitno;

  // register bit number only for the first four operations
  always_comb begin
    if (bitno_from_reg && (op == bit_set_op || op == bit_clear_op ||
                           op == bit_invert_op || op == bit_test_op)) begin
      nxt_bitno = bitno_reg[BITNO_W-1:0];
    end else begin
      nxt_bitno = imm_bitno;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_ff    <= bit_set_op;
      bitno_ff <= '0;
      carry_ff <= 1'b0;
    end else if (start && state_ff == st_idle) begin
      op_ff    <= op;
      bitno_ff <= nxt_bitno;
      carry_ff <= carry_in;
    end
  end

  // operand is the register byte or the byte just read
  logic [BYTE_W-1:0] reg_op_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_op_ff <= BYTE_ZERO;
    end else if (start && state_ff == st_idle) begin
      reg_op_ff <= reg_operand;
    end else if (state_ff == st_read && mem_ack) begin
      reg_op_ff <= mem_rdata;
    end
  end

  // ----------------------------------------
  // bit datapath
  // ----------------------------------------
  always_comb begin
    operand     = (state_ff == st_read) ? mem_rdata : reg_op_ff;
    mask        = BYTE_ONE << bitno_ff;
    sel_bit     = operand[bitno_ff];
    new_byte    = operand;
    writes_byte = 1'b0;
    new_carry   = carry_ff;
    carry_op    = 1'b0;
    unique case (op_ff)
      bit_set_op: begin
        new_byte = operand | mask;
        writes_byte = 1'b1;
      end
      bit_clear_op: begin
        new_byte = operand & ~mask;
        writes_byte = 1'b1;
      end
      bit_invert_op: begin
        new_byte = operand ^ mask;
        writes_byte = 1'b1;
      end
      bit_test_op: begin
        new_byte = operand;
      end
      carry_and_op: begin
        new_carry = carry_ff & sel_bit;
        carry_op = 1'b1;
      end
      carry_and_inverted_op: begin
        new_carry = carry_ff & ~sel_bit;
        carry_op = 1'b1;
      end
      carry_or_op: begin
        new_carry = carry_ff | sel_bit;
        carry_op = 1'b1;
      end
      carry_or_inverted_op: begin
        new_carry = carry_ff | ~sel_bit;
        carry_op = 1'b1;
      end
      carry_xor_op: begin
        new_carry = carry_ff ^ sel_bit;
        carry_op = 1'b1;
      end
      carry_xor_inverted_op: begin
        new_carry = carry_ff ^ ~sel_bit;
        carry_op = 1'b1;
      end
      bit_to_carry_op: begin
        new_carry = sel_bit;
        carry_op = 1'b1;
      end
      inverted_bit_to_carry_op: begin
        new_carry = ~sel_bit;
        carry_op = 1'b1;
      end
      carry_to_bit_op: begin
        new_byte = carry_ff ? (operand | mask) : (operand & ~mask);
        writes_byte = 1'b1;
      end
      inverted_carry_to_bit_op: begin
        new_byte = carry_ff ? (operand & ~mask) : (operand | mask);
        writes_byte = 1'b1;
      end
      default: begin
        new_byte = operand;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic mem_ff;
  logic exec;
  // exec marks the cycle in which the byte is ready to modify
  assign exec = (state_ff == st_write && !mem_ff) ||
                (state_ff == st_read && mem_ack);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= st_idle;
      mem_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        st_idle: begin
          if (start) begin
            mem_ff   <= use_mem;
            state_ff <= use_mem ? st_read : st_write;
          end
        end
        st_read: begin
          if (mem_ack) begin
            state_ff <= writes_byte ? st_write : st_idle;
          end
        end
        st_write: begin
          if (!mem_ff || mem_ack) begin
            state_ff <= st_idle;
          end
        end
        default: state_ff <= st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // memory strobes, held until acknowledged
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= BYTE_ZERO;
    end else begin
      if (state_ff == st_idle && start && use_mem) begin
        mem_rd_ff <= 1'b1;
      end else if (mem_ack) begin
        mem_rd_ff <= 1'b0;
      end
      if (state_ff == st_read && mem_ack && writes_byte) begin
        mem_wr_ff    <= 1'b1;
        mem_wdata_ff <= new_byte;
      end else if (mem_wr_ff && mem_ack) begin
        mem_wr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // results and flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_result_ff <= BYTE_ZERO;
      reg_we_ff     <= 1'b0;
      carry_out_ff  <= 1'b0;
      carry_we_ff   <= 1'b0;
      zero_out_ff   <= 1'b0;
      zero_we_ff    <= 1'b0;
    end else begin
      reg_we_ff   <= exec && !mem_ff && writes_byte;
      carry_we_ff <= exec && carry_op;
      zero_we_ff  <= exec && op_ff == bit_test_op;
      if (exec && !mem_ff && writes_byte) begin
        reg_result_ff <= new_byte;
      end
      if (exec && carry_op) begin
        carry_out_ff <= new_carry;
      end
      if (exec && op_ff == bit_test_op) begin
        zero_out_ff <= ~sel_bit;
      end
    end
  end

  // busy while sequencing; done pulses as the operation ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff == st_idle) ? start :
                 !((state_ff == st_write && (!mem_ff || mem_ack)) ||
                   (state_ff == st_read && mem_ack && !writes_byte));
      done_ff <= (state_ff == st_write && (!mem_ff || mem_ack)) ||
                 (state_ff == st_read && mem_ack && !writes_byte);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  set_result_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && !mem_ff && op_ff == bit_set_op |=> reg_result_ff == ($past(operand) | $past(mask)))
    else $error("set result wrong");
  clear_result_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == bit_clear_op |-> new_byte[bitno_ff] == 1'b0)
    else $error("clear bit not zero");
  invert_result_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == bit_invert_op |-> (new_byte ^ operand) == mask)
    else $error("invert changed wrong bits");
  test_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == bit_test_op |=> zero_we_ff && zero_out_ff == !$past(sel_bit) && !reg_we_ff)
    else $error("test zero flag wrong");
  carry_and_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_and_op |=> carry_we_ff && carry_out_ff == $past(carry_ff & sel_bit))
    else $error("carry and wrong");
  carry_xor_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_xor_inverted_op |=>
      carry_out_ff == ($past(carry_ff) == $past(sel_bit)))
    else $error("inverted carry xor wrong");
  store_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_to_bit_op |-> new_byte[bitno_ff] == carry_ff &&
      (new_byte & ~mask) == (operand & ~mask))
    else $error("store bit wrong");
  imm_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    start && state_ff == st_idle && op inside {[carry_and_op:inverted_carry_to_bit_op]} |=>
      bitno_ff == $past(imm_bitno))
    else $error("carry op used register bit");
  rmw_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == st_read && mem_ack && writes_byte |=> mem_wr_ff && !mem_rd_ff && state_ff == st_write)
    else $error("write back missing");
  reg_bitno_a: assert property (@(posedge clk) disable iff (!reset_n)
    start && state_ff == st_idle && bitno_from_reg && op inside {[bit_set_op:bit_test_op]} |=>
      bitno_ff == $past(bitno_reg[BITNO_W-1:0]))
    else $error("register bit number not used");
  carry_and_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_and_inverted_op |=> carry_out_ff == $past(carry_ff & ~sel_bit))
    else $error("inverted carry and wrong");
  carry_or_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_or_op |=> carry_out_ff == $past(carry_ff | sel_bit))
    else $error("carry or wrong");
  carry_or_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_or_inverted_op |=> carry_out_ff == $past(carry_ff | ~sel_bit))
    else $error("inverted carry or wrong");
  carry_xor_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == carry_xor_op |=> carry_out_ff == $past(carry_ff ^ sel_bit))
    else $error("carry xor wrong");
  bit_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == bit_to_carry_op |=> carry_we_ff && carry_out_ff == $past(sel_bit))
    else $error("bit load wrong");
  inv_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == inverted_bit_to_carry_op |=> carry_out_ff == !$past(sel_bit))
    else $error("inverted bit load wrong");
  inv_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && op_ff == inverted_carry_to_bit_op |-> new_byte[bitno_ff] == !carry_ff &&
      (new_byte & ~mask) == (operand & ~mask))
    else $error("inverted store bit wrong");
  mem_wdata_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == st_read && mem_ack && writes_byte |=>
      (mem_wdata_ff & ~$past(mask)) == ($past(mem_rdata) & ~$past(mask)))
    else $error("write back changed other bits");
  carry_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && carry_op |=> !zero_we_ff && !reg_we_ff && !mem_wr_ff)
    else $error("carry op touched operand or zero");
endmodule
`default_nettype wire

// ---- rtl/bit_manip_pkg.sv ----
// constants and operation codes for the bit manipulation datapath
`default_nettype none
package bit_manip_pkg;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned BITNO_W = 3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

  // operation select
  typedef enum logic [3:0] {
    bit_set_op               = 4'h0,
    bit_clear_op             = 4'h1,
    bit_invert_op            = 4'h2,
    bit_test_op              = 4'h3,
    carry_and_op             = 4'h4,
    carry_and_inverted_op    = 4'h5,
    carry_or_op              = 4'h6,
    carry_or_inverted_op     = 4'h7,
    carry_xor_op             = 4'h8,
    carry_xor_inverted_op    = 4'h9,
    bit_to_carry_op          = 4'ha,
    inverted_bit_to_carry_op = 4'hb,
    carry_to_bit_op          = 4'hc,
    inverted_carry_to_bit_op = 4'hd
  } op_t;

  // sequencer states
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_read  = 2'b01,
    st_write = 2'b10
  } state_t;
endpackage
`default_nettype wire

// ---- tb/bit_manipulation_unit_bench.sv ----
// self-checking bench for the bit manipulation datapath
`default_nettype none
module bit_manipulation_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import bit_manip_pkg::*;

  // one table row: inputs, then expected results and enables {reg, carry, zero}
  typedef struct packed {
    op_t        op;
    logic       fr;
    logic [2:0] imm;
    logic [7:0] breg;
    logic [7:0] opnd;
    logic       cin;
    logic [7:0] res;
    logic [2:0] we;
    logic       c;
    logic       z;
  } row_t;

  logic       clk, reset_n, start, use_mem, bitno_from_reg, carry_in, mem_ack;
  op_t        op;
  logic [2:0] imm_bitno;
  logic [7:0] bitno_reg, reg_operand, mem_rdata, reg_result_ff, mem_wdata_ff;
  logic       busy_ff, done_ff, reg_we_ff, carry_out_ff, carry_we_ff;
  logic       zero_out_ff, zero_we_ff, mem_rd_ff, mem_wr_ff;
  int         n_fail, total_checks, n_cyc, cyc, k;
  row_t       r;

  // ordinary cases, one operation per row
  row_t rows [19] = '{
    '{bit_set_op, 1'b0, 3'h7, 8'h00, 8'h00, 1'b0, 8'h80, 3'h4, 1'b0, 1'b0},
    '{bit_set_op, 1'b1, 3'h0, 8'hfa, 8'h00, 1'b0, 8'h04, 3'h4, 1'b0, 1'b0},
    '{bit_clear_op, 1'b0, 3'h0, 8'h00, 8'hff, 1'b0, 8'hfe, 3'h4, 1'b0, 1'b0},
    '{bit_clear_op, 1'b1, 3'h0, 8'h0d, 8'hff, 1'b0, 8'hdf, 3'h4, 1'b0, 1'b0},
    '{bit_invert_op, 1'b0, 3'h3, 8'h00, 8'h0f, 1'b0, 8'h07, 3'h4, 1'b0, 1'b0},
    '{bit_invert_op, 1'b0, 3'h3, 8'h00, 8'h00, 1'b0, 8'h08, 3'h4, 1'b0, 1'b0},
    '{bit_test_op, 1'b0, 3'h6, 8'h00, 8'hbf, 1'b0, 8'h00, 3'h1, 1'b0, 1'b1},
    '{bit_test_op, 1'b1, 3'h0, 8'h01, 8'h02, 1'b0, 8'h00, 3'h1, 1'b0, 1'b0},
    '{carry_and_op, 1'b0, 3'h2, 8'h00, 8'h04, 1'b1, 8'h00, 3'h2, 1'b1, 1'b0},
    '{carry_and_op, 1'b1, 3'h1, 8'h02, 8'h04, 1'b1, 8'h00, 3'h2, 1'b0, 1'b0},
    '{carry_and_inverted_op, 1'b0, 3'h2, 8'h00, 8'h04, 1'b1, 8'h00, 3'h2, 1'b0, 1'b0},
    '{carry_or_op, 1'b0, 3'h5, 8'h00, 8'h20, 1'b0, 8'h00, 3'h2, 1'b1, 1'b0},
    '{carry_or_inverted_op, 1'b0, 3'h5, 8'h00, 8'h20, 1'b0, 8'h00, 3'h2, 1'b0, 1'b0},
    '{carry_xor_op, 1'b0, 3'h0, 8'h00, 8'h01, 1'b1, 8'h00, 3'h2, 1'b0, 1'b0},
    '{carry_xor_inverted_op, 1'b0, 3'h0, 8'h00, 8'h01, 1'b1, 8'h00, 3'h2, 1'b1, 1'b0},
    '{bit_to_carry_op, 1'b0, 3'h4, 8'h00, 8'h10, 1'b0, 8'h00, 3'h2, 1'b1, 1'b0},
    '{inverted_bit_to_carry_op, 1'b0, 3'h4, 8'h00, 8'h10, 1'b0, 8'h00, 3'h2, 1'b0, 1'b0},
    '{carry_to_bit_op, 1'b0, 3'h1, 8'h00, 8'hff, 1'b0, 8'hfd, 3'h4, 1'b0, 1'b0},
    '{inverted_carry_to_bit_op, 1'b0, 3'h6, 8'h00, 8'h00, 1'b0, 8'h40, 3'h4, 1'b0, 1'b0}
  };

  bit_manip_unit u_bit_manip_unit (
    .clk            (clk),
    .reset_n        (reset_n),
    .start          (start),
    .op             (op),
    .use_mem        (use_mem),
    .bitno_from_reg (bitno_from_reg),
    .imm_bitno      (imm_bitno),
    .bitno_reg      (bitno_reg),
    .reg_operand    (reg_operand),
    .carry_in       (carry_in),
    .mem_rdata      (mem_rdata),
    .mem_ack        (mem_ack),
    .busy_ff        (busy_ff),
    .done_ff        (done_ff),
    .reg_result_ff  (reg_result_ff),
    .reg_we_ff      (reg_we_ff),
    .carry_out_ff   (carry_out_ff),
    .carry_we_ff    (carry_we_ff),
    .zero_out_ff    (zero_out_ff),
    .zero_we_ff     (zero_we_ff),
    .mem_rd_ff      (mem_rd_ff),
    .mem_wr_ff      (mem_wr_ff),
    .mem_wdata_ff   (mem_wdata_ff)
  );

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle start pulse, entered just after an edge
  task automatic launch(op_t o, logic um, logic fr, logic [2:0] n, logic [7:0] br,
                        logic [7:0] opnd, logic cin);
    op = o;
    use_mem = um;
    bitno_from_reg = fr;
    imm_bitno = n;
    bitno_reg = br;
    reg_operand = opnd;
    carry_in = cin;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask

  task automatic wait_done(output int c);
    c = 0;
    while (done_ff !== 1'b1 && c < 20) begin
      @(posedge clk);
      #1 c++;
    end
  endtask

  // one-cycle acknowledge; read data shows only with it
  task automatic ack(logic [7:0] rd);
    mem_ack = 1'b1;
    mem_rdata = rd;
    @(posedge clk);
    #1 mem_ack = 1'b0;
    mem_rdata = ~rd;
  endtask

  task automatic wait_rd();
    for (k = 0; k < 10 && mem_rd_ff !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    start = 1'b0;
    op = bit_set_op;
    use_mem = 1'b0;
    bitno_from_reg = 1'b0;
    imm_bitno = 3'h0;
    bitno_reg = 8'h00;
    reg_operand = 8'h00;
    carry_in = 1'b0;
    mem_rdata = 8'h00;
    mem_ack = 1'b0;
    n_fail = 0;
    total_checks = 0;
    n_cyc = 0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("idle", {busy_ff, done_ff, reg_we_ff, carry_we_ff, zero_we_ff,
        mem_rd_ff, mem_wr_ff, 1'b0}, 8'h00);
    // table pass, each start after the first given in the previous done cycle
    foreach (rows[i]) begin
      r = rows[i];
      launch(r.op, 1'b0, r.fr, r.imm, r.breg, r.opnd, r.cin);
      wait_done(cyc);
      chk("latency", 8'(cyc), 8'h01);
      chk("enables", {5'h00, reg_we_ff, carry_we_ff, zero_we_ff}, {5'h00, r.we});
      if (r.we[2]) chk("result", reg_result_ff, r.res);
      if (r.we[1]) chk("carry", {7'h00, carry_out_ff}, {7'h00, r.c});
      if (r.we[0]) chk("zero", {7'h00, zero_out_ff}, {7'h00, r.z});
    end
    // start while busy is ignored
    launch(bit_set_op, 1'b0, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    launch(bit_clear_op, 1'b0, 1'b0, 3'h1, 8'h00, 8'hff, 1'b0);
    wait_done(cyc);
    chk("busy result", reg_result_ff, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("no second done", {7'h00, done_ff}, 8'h00);
    // memory invert, bit number from register: read, modify, write back
    launch(bit_invert_op, 1'b1, 1'b1, 3'h0, 8'h03, 8'h00, 1'b0);
    wait_rd();
    chk("mem read", {7'h00, mem_rd_ff}, 8'h01);
    ack(8'ha5);
    for (k = 0; k < 10 && mem_wr_ff !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("mem wdata", mem_wdata_ff, 8'had);
    ack(8'h00);
    chk("mem done", {6'h00, done_ff, reg_we_ff}, 8'h02);
    // memory carry op: no write cycle
    launch(carry_xor_inverted_op, 1'b1, 1'b0, 3'h7, 8'h00, 8'h00, 1'b1);
    wait_rd();
    ack(8'ha5);
    chk("mem flag", {5'h00, done_ff, carry_we_ff, carry_out_ff}, 8'h07);
    chk("no mem write", {7'h00, mem_wr_ff}, 8'h00);
    // reset in mid read, then a clean operation
    @(posedge clk);
    #1 launch(bit_set_op, 1'b1, 1'b0, 3'h2, 8'h00, 8'h00, 1'b0);
    wait_rd();
    reset_n = 1'b0;
    #1 chk("reset mid op", {6'h00, busy_ff, mem_rd_ff}, 8'h00);
    @(posedge clk);
    #1 reset_n = 1'b1;
    launch(carry_to_bit_op, 1'b0, 1'b0, 3'h7, 8'h00, 8'h0f, 1'b1);
    wait_done(cyc);
    chk("after reset", reg_result_ff, 8'h8f);
    print_verdict();
  end
endmodule
`default_nettype wire
